// ### had_cmd_queue.sv
// tag plus data queue in front of the drawing engine
`timescale 1ns/1ns
module had_cmd_queue (
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst,
	// fill side
	input  wire logic                        push,
	input  wire logic [had_pkg::TAG_W-1:0]   push_tag,
	input  wire logic [31:0]                 push_data,
	output logic                             full,
	output logic      [had_pkg::Q_AW:0]      free,
	// drain side
	output logic                             pop_valid,
	input  wire logic                        pop_ready,
	output logic      [had_pkg::TAG_W-1:0]   pop_tag,
	output logic      [31:0]                 pop_data
);

	logic [had_pkg::TAG_W+31:0] mem_q [had_pkg::Q_DEPTH];
	logic [had_pkg::Q_AW:0]     wr_r;
	logic [had_pkg::Q_AW:0]     wr_nxt;
	logic [had_pkg::Q_AW:0]     rd_r;
	logic [had_pkg::Q_AW:0]     rd_nxt;
	logic [had_pkg::Q_AW:0]     used;
	logic                       do_push;
	logic                       do_pop;

	always_comb begin
		used      = wr_r - rd_r;
		full      = used == (had_pkg::Q_AW+1)'(had_pkg::Q_DEPTH);
		free      = (had_pkg::Q_AW+1)'(had_pkg::Q_DEPTH) - used;
		pop_valid = used != '0;
		do_push   = push && !full;
		do_pop    = pop_valid && pop_ready;
		wr_nxt    = do_push ? wr_r + 1'b1 : wr_r;
		rd_nxt    = do_pop ? rd_r + 1'b1 : rd_r;
		{pop_tag, pop_data} = mem_q[rd_r[had_pkg::Q_AW-1:0]];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_r <= '0;
			rd_r <= '0;
		end else begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (do_push) begin
			mem_q[wr_r[had_pkg::Q_AW-1:0]] <= {push_tag, push_data};
		end
	end

endmodule : had_cmd_queue

// ### had_decode.sv
// host aperture decoder: config space, apertures, sub-windows, swap, queue
`timescale 1ns/1ns
module had_decode #(
	parameter bit LEGACY_EN = 1'b1
) (
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst,
	// host request
	input  wire logic                        h_req,
	input  wire logic [1:0]                  h_space,
	input  wire logic                        h_we,
	input  wire logic [31:0]                 h_addr,
	input  wire logic [31:0]                 h_wdata,
	input  wire logic [3:0]                  h_be,
	output logic                             h_ready,
	output logic                             h_ack,
	output logic                             h_hit,
	output logic      [31:0]                 h_rdata,
	// sub-window target
	output logic                             tgt_req,
	output had_pkg::had_dst_t                tgt_dst,
	output logic                             tgt_we,
	output logic      [had_pkg::OFF_W-1:0]   tgt_off,
	output logic      [31:0]                 tgt_wdata,
	output logic      [3:0]                  tgt_be,
	output logic                             tgt_swap,
	input  wire logic                        tgt_ack,
	input  wire logic [31:0]                 tgt_rdata,
	// drawing engine
	output logic                             de_valid,
	input  wire logic                        de_ready,
	output logic      [had_pkg::TAG_W-1:0]   de_tag,
	output logic      [31:0]                 de_data,
	input  wire logic                        de_busy,
	output logic                             draw_go,
	// sync completion
	input  wire logic                        sync_irq_en,
	input  wire logic                        sync_ack,
	output logic                             sync_done,
	output logic                             sync_irq
);

	had_pkg::had_state_t             st_r, st_nxt;
	logic [1:0]                      sp_r, sp_nxt;
	logic                            we_r, we_nxt;
	logic [31:0]                     a_r, a_nxt;
	logic [31:0]                     wd_r, wd_nxt;
	logic [3:0]                      be_r, be_nxt;
	logic [31:0]                     rd_r, rd_nxt;
	logic                            hit_r, hit_nxt;
	logic [1:0]                      cmd_r, cmd_nxt;
	logic [31:0]                     bar0_r, bar0_nxt;
	logic [31:0]                     bar1_r, bar1_nxt;
	logic [31:0]                     bar2_r, bar2_nxt;
	logic [31:0]                     rom_r, rom_nxt;
	logic                            spend_r, spend_nxt;
	logic                            sdone_r, sdone_nxt;
	had_pkg::had_dst_t               dst;
	logic [had_pkg::OFF_W-1:0]       off;
	logic                            swap;
	logic                            local_hit;
	logic                            q_push;
	logic                            q_full;
	logic [had_pkg::Q_AW:0]          q_free;
	logic [had_pkg::TAG_W-1:0]       q_tag;
	logic [31:0]                     wd_sw;
	logic                            done_now;
	logic [31:0]                     cfg_rd;
	logic [31:0]                     wmask;
	logic [31:0]                     cfg_wd;
	logic                            pop;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// byte lane mask for config writes
	for (genvar i = 0; i < 4; i++) begin : g_lane
		assign wmask[8*i +: 8] = {8{be_r[i]}};
	end

	// aperture and sub-window decode
	always_comb begin
		dst  = had_pkg::DST_MISS;
		off  = '0;
		swap = 1'b0;
		if (sp_r == had_pkg::SP_CFG) begin
			dst = had_pkg::DST_CFG;
		end else if (sp_r == had_pkg::SP_MEM && cmd_r[had_pkg::CMD_MEM_BIT]) begin
			if ((a_r & had_pkg::BAR0_MASK) == bar0_r) begin
				off = {6'h00, a_r[16:0]};
				if (a_r[had_pkg::DRAW_BIT]) begin
					dst = had_pkg::DST_DRAW;
				end else begin
					case (a_r[14:12])
						had_pkg::SUB_CTRL:   dst = had_pkg::DST_CTRL;
						had_pkg::SUB_MEMCTL: dst = had_pkg::DST_MEMCTL;
						had_pkg::SUB_QUEUE:  dst = had_pkg::DST_QUEUE;
						had_pkg::SUB_VIDTIM: dst = had_pkg::DST_VIDTIM;
						had_pkg::SUB_PAL:    dst = had_pkg::DST_PAL;
						had_pkg::SUB_VS:     dst = a_r[had_pkg::VS_HALF_BIT] ?
							had_pkg::DST_VSCTL : had_pkg::DST_VSBUS;
						had_pkg::SUB_LEGCTL: dst = had_pkg::DST_LEGCTL;
						default:             dst = had_pkg::DST_RSVD;
					endcase
				end
				// upper copy swaps except video streams
				swap = a_r[had_pkg::SWAP_BIT] && dst != had_pkg::DST_VSBUS &&
					dst != had_pkg::DST_VSCTL;
			end else if ((a_r & had_pkg::BAR12_MASK) == bar1_r) begin
				dst = had_pkg::DST_MEM1;
				off = a_r[had_pkg::OFF_W-1:0];
			end else if ((a_r & had_pkg::BAR12_MASK) == bar2_r) begin
				dst = had_pkg::DST_MEM2;
				off = a_r[had_pkg::OFF_W-1:0];
			end else if (rom_r[had_pkg::ROM_EN_BIT] &&
				(a_r & had_pkg::ROM_MASK) == (rom_r & had_pkg::ROM_MASK)) begin
				dst = had_pkg::DST_ROM;
				off = {7'h00, a_r[15:0]};
			end else if (LEGACY_EN && a_r >= had_pkg::LEG_MEM_LO &&
				a_r <= had_pkg::LEG_MEM_HI) begin
				dst = had_pkg::DST_LEGACY;
				off = a_r[had_pkg::OFF_W-1:0];
			end
		end else if (sp_r == had_pkg::SP_IO && cmd_r[had_pkg::CMD_IO_BIT] && LEGACY_EN &&
			a_r >= had_pkg::LEG_IO_LO && a_r <= had_pkg::LEG_IO_HI) begin
			dst = had_pkg::DST_LEGACY;
			off = a_r[had_pkg::OFF_W-1:0];
		end
	end

	assign wd_sw = swap ? had_pkg::bswap(wd_r) : wd_r;

	// handled locally, never sent to a target
	assign local_hit = dst == had_pkg::DST_CFG || dst == had_pkg::DST_RSVD ||
		dst == had_pkg::DST_MISS || dst == had_pkg::DST_QUEUE ||
		(dst == had_pkg::DST_DRAW && we_r);
	// writes to the queue or draw window always go into the queue, busy engine or not
	assign q_push = st_r == had_pkg::ST_BUSY && we_r &&
		(dst == had_pkg::DST_QUEUE || dst == had_pkg::DST_DRAW);
	assign q_tag  = dst == had_pkg::DST_QUEUE ?
		{1'b1, 3'h0, a_r[11:2]} : {1'b0, a_r[14:2]};
	assign done_now = local_hit ? !(q_push && q_full) : tgt_ack;

	assign h_ready   = st_r == had_pkg::ST_IDLE;
	assign h_ack     = st_r == had_pkg::ST_DONE;
	assign h_hit     = hit_r;
	assign h_rdata   = rd_r;
	assign tgt_req   = st_r == had_pkg::ST_BUSY && !local_hit;
	assign tgt_dst   = dst;
	assign tgt_we    = we_r;
	assign tgt_off   = off;
	assign tgt_wdata = wd_sw;
	assign tgt_be    = swap ? had_pkg::beswap(be_r) : be_r;
	assign tgt_swap  = swap;

	always_comb begin
		case (a_r[7:2])
			had_pkg::CFG_ID_IDX:   cfg_rd = had_pkg::CFG_ID_VAL;
			had_pkg::CFG_CMD_IDX:  cfg_rd = {30'h0, cmd_r};
			had_pkg::CFG_BAR0_IDX: cfg_rd = bar0_r;
			had_pkg::CFG_BAR1_IDX: cfg_rd = bar1_r;
			had_pkg::CFG_BAR2_IDX: cfg_rd = bar2_r;
			had_pkg::CFG_ROM_IDX:  cfg_rd = rom_r;
			default:               cfg_rd = 32'h0;
		endcase
		cfg_wd = (cfg_rd & ~wmask) | (wd_r & wmask);
	end

	// request sequencing and config state
	always_comb begin
		st_nxt   = st_r;
		sp_nxt   = sp_r;
		we_nxt   = we_r;
		a_nxt    = a_r;
		wd_nxt   = wd_r;
		be_nxt   = be_r;
		rd_nxt   = rd_r;
		hit_nxt  = hit_r;
		cmd_nxt  = cmd_r;
		bar0_nxt = bar0_r;
		bar1_nxt = bar1_r;
		bar2_nxt = bar2_r;
		rom_nxt  = rom_r;
		case (st_r)
			had_pkg::ST_IDLE: begin
				if (h_req) begin
					st_nxt = had_pkg::ST_BUSY;
					sp_nxt = h_space;
					we_nxt = h_we;
					a_nxt  = h_addr;
					wd_nxt = h_wdata;
					be_nxt = h_be;
				end
			end
			had_pkg::ST_BUSY: begin
				if (done_now) begin
					st_nxt  = had_pkg::ST_DONE;
					hit_nxt = dst != had_pkg::DST_MISS;
					rd_nxt  = 32'h0;
					if (!we_r) begin
						if (dst == had_pkg::DST_CFG) begin
							rd_nxt = cfg_rd;
						end else if (dst == had_pkg::DST_QUEUE) begin
							rd_nxt = {23'h0, q_free};
						end else if (!local_hit) begin
							rd_nxt = swap ? had_pkg::bswap(tgt_rdata) : tgt_rdata;
						end
					end
					if (dst == had_pkg::DST_CFG && we_r) begin
						case (a_r[7:2])
							had_pkg::CFG_CMD_IDX:  cmd_nxt  = cfg_wd[1:0];
							had_pkg::CFG_BAR0_IDX: bar0_nxt = cfg_wd & had_pkg::BAR0_MASK;
							had_pkg::CFG_BAR1_IDX: bar1_nxt = cfg_wd & had_pkg::BAR12_MASK;
							had_pkg::CFG_BAR2_IDX: bar2_nxt = cfg_wd & had_pkg::BAR12_MASK;
							had_pkg::CFG_ROM_IDX:  rom_nxt  = cfg_wd &
								(had_pkg::ROM_MASK | 32'h0000_0001);
							default:               cmd_nxt  = cmd_r;
						endcase
					end
				end
			end
			had_pkg::ST_DONE: st_nxt = had_pkg::ST_IDLE;
			default:          st_nxt = had_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r   <= had_pkg::ST_IDLE;
			sp_r   <= had_pkg::SP_CFG;
			we_r   <= 1'b0;
			a_r    <= 32'h0;
			wd_r   <= 32'h0;
			be_r   <= 4'h0;
			rd_r   <= 32'h0;
			hit_r  <= 1'b0;
			cmd_r  <= had_pkg::CMD_RST;
			bar0_r <= had_pkg::BAR_RST;
			bar1_r <= had_pkg::BAR_RST;
			bar2_r <= had_pkg::BAR_RST;
			rom_r  <= had_pkg::BAR_RST;
		end else begin
			st_r   <= st_nxt;
			sp_r   <= sp_nxt;
			we_r   <= we_nxt;
			a_r    <= a_nxt;
			wd_r   <= wd_nxt;
			be_r   <= be_nxt;
			rd_r   <= rd_nxt;
			hit_r  <= hit_nxt;
			cmd_r  <= cmd_nxt;
			bar0_r <= bar0_nxt;
			bar1_r <= bar1_nxt;
			bar2_r <= bar2_nxt;
			rom_r  <= rom_nxt;
		end
	end

	had_cmd_queue u_queue (
		.clk       (clk),
		.rst       (rst),
		.push      (q_push),
		.push_tag  (q_tag),
		.push_data (wd_sw),
		.full      (q_full),
		.free      (q_free),
		.pop_valid (de_valid),
		.pop_ready (de_ready),
		.pop_tag   (de_tag),
		.pop_data  (de_data)
	);

	assign pop = de_valid && de_ready && !de_tag[had_pkg::TAG_RAW_BIT];
	// drawing starts only on the command entry
	assign draw_go = pop && de_tag == had_pkg::TAG_RENDER;

	// sync flush tracking
	always_comb begin
		spend_nxt = spend_r;
		sdone_nxt = sdone_r;
		if (sync_ack) begin
			sdone_nxt = 1'b0;
		end
		// done once queue drained and engine idle; set beats clear
		if (spend_r && !de_valid && !de_busy) begin
			spend_nxt = 1'b0;
			sdone_nxt = 1'b1;
		end
		if (pop && de_tag == had_pkg::TAG_SYNC) begin
			spend_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			spend_r <= 1'b0;
			sdone_r <= 1'b0;
		end else begin
			spend_r <= spend_nxt;
			sdone_r <= sdone_nxt;
		end
	end

	assign sync_done = sdone_r;
	assign sync_irq  = sdone_r && sync_irq_en;

	ack_single_a: assert property (h_ack |=> !h_ack && h_ready)
		else $error("host ack longer than one cycle");
	bar0_align_a: assert property (bar0_r[16:0] == 17'h0)
		else $error("region zero base not 128K aligned");
	swap_bytes_a: assert property (tgt_req && dst == had_pkg::DST_CTRL && a_r[had_pkg::SWAP_BIT]
		|-> tgt_wdata == {wd_r[7:0], wd_r[15:8], wd_r[23:16], wd_r[31:24]})
		else $error("upper control write not byte reversed");
	vs_noswap_a: assert property (tgt_req && (dst == had_pkg::DST_VSBUS ||
		dst == had_pkg::DST_VSCTL) |-> !tgt_swap && tgt_wdata == wd_r)
		else $error("video-stream access swapped");
	rsvd_zero_a: assert property (h_ack && dst == had_pkg::DST_RSVD
		|-> h_rdata == 32'h0 && !tgt_req)
		else $error("reserved window read not zero");
	queue_stall_a: assert property (st_r == had_pkg::ST_BUSY && q_push && q_full
		|=> st_r == had_pkg::ST_BUSY)
		else $error("write completed into a full queue");
	sync_hold_a: assert property (sync_done && !sync_ack |=> sync_done)
		else $error("sync completion lost without ack");
	bypass_off_a: assert property (tgt_req && dst == had_pkg::DST_MEM1
		|-> tgt_off == a_r[22:0] && !tgt_swap)
		else $error("bypass offset wrong");
	mem_off_a: assert property (st_r == had_pkg::ST_BUSY && sp_r == had_pkg::SP_MEM &&
		!cmd_r[had_pkg::CMD_MEM_BIT] |-> dst == had_pkg::DST_MISS)
		else $error("memory decode while disabled");
	draw_cmd_a: assert property (de_valid && de_ready && de_tag[had_pkg::TAG_RAW_BIT]
		|-> !draw_go)
		else $error("raw queue entry started drawing");

endmodule : had_decode

// ### had_pkg.sv
// constants and types for the host aperture address decoder
package had_pkg;

	// bus spaces seen on the host request port
	localparam logic [1:0]  SP_CFG       = 2'h0;
	localparam logic [1:0]  SP_MEM       = 2'h1;
	localparam logic [1:0]  SP_IO        = 2'h2;

	// configuration space layout, word indices
	localparam int unsigned CFG_BYTES    = 256;
	localparam int unsigned CFG_IW       = 6;
	localparam logic [5:0]  CFG_ID_IDX   = 6'h00;
	localparam logic [5:0]  CFG_CMD_IDX  = 6'h01;
	localparam logic [5:0]  CFG_BAR0_IDX = 6'h04;
	localparam logic [5:0]  CFG_BAR1_IDX = 6'h05;
	localparam logic [5:0]  CFG_BAR2_IDX = 6'h06;
	localparam logic [5:0]  CFG_ROM_IDX  = 6'h0c;
	localparam int unsigned CMD_IO_BIT   = 0;
	localparam int unsigned CMD_MEM_BIT  = 1;
	localparam int unsigned ROM_EN_BIT   = 0;
	localparam logic [1:0]  CMD_RST      = 2'h0;
	localparam logic [31:0] BAR_RST      = 32'h0000_0000;

	// aperture sizes as base masks: 128K, 8M, 64K
	localparam logic [31:0] BAR0_MASK    = 32'hfffe_0000;
	localparam logic [31:0] BAR12_MASK   = 32'hff80_0000;
	localparam logic [31:0] ROM_MASK     = 32'hffff_0000;

	// fixed legacy video addresses
	localparam logic [31:0] LEG_MEM_LO   = 32'h000a_0000;
	localparam logic [31:0] LEG_MEM_HI   = 32'h000b_ffff;
	localparam logic [31:0] LEG_IO_LO    = 32'h0000_03b0;
	localparam logic [31:0] LEG_IO_HI    = 32'h0000_03df;

	// region zero offset fields
	localparam int unsigned OFF_W        = 23;
	localparam int unsigned SWAP_BIT     = 16;
	localparam int unsigned DRAW_BIT     = 15;
	localparam int unsigned VS_HALF_BIT  = 11;
	localparam logic [2:0]  SUB_CTRL     = 3'h0;
	localparam logic [2:0]  SUB_MEMCTL   = 3'h1;
	localparam logic [2:0]  SUB_QUEUE    = 3'h2;
	localparam logic [2:0]  SUB_VIDTIM   = 3'h3;
	localparam logic [2:0]  SUB_PAL      = 3'h4;
	localparam logic [2:0]  SUB_VS       = 3'h5;
	localparam logic [2:0]  SUB_LEGCTL   = 3'h6;

	// drawing command queue
	localparam int unsigned Q_DEPTH      = 256;
	localparam int unsigned Q_AW         = 8;
	localparam int unsigned TAG_W        = 14;
	localparam int unsigned TAG_RAW_BIT  = 13;
	localparam logic [13:0] TAG_RENDER   = 14'h0007;
	localparam logic [13:0] TAG_SYNC     = 14'h0063;

	// identity word; value is arbitrary
	localparam logic [31:0] CFG_ID_VAL   = 32'h5a5a_a5a5;

	typedef enum logic [15:0] {
		DST_CFG    = 16'h0001,
		DST_CTRL   = 16'h0002,
		DST_MEMCTL = 16'h0004,
		DST_QUEUE  = 16'h0008,
		DST_VIDTIM = 16'h0010,
		DST_PAL    = 16'h0020,
		DST_VSBUS  = 16'h0040,
		DST_VSCTL  = 16'h0080,
		DST_LEGCTL = 16'h0100,
		DST_RSVD   = 16'h0200,
		DST_DRAW   = 16'h0400,
		DST_MEM1   = 16'h0800,
		DST_MEM2   = 16'h1000,
		DST_ROM    = 16'h2000,
		DST_LEGACY = 16'h4000,
		DST_MISS   = 16'h8000
	} had_dst_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_BUSY = 3'b010,
		ST_DONE = 3'b100
	} had_state_t;

	function automatic logic [31:0] bswap(input logic [31:0] d);
		bswap = {d[7:0], d[15:8], d[23:16], d[31:24]};
	endfunction : bswap

	function automatic logic [3:0] beswap(input logic [3:0] b);
		beswap = {b[0], b[1], b[2], b[3]};
	endfunction : beswap

endpackage : had_pkg

// ### had_tgt_model.sv
// sub-window target and drawing engine responder for the decoder
`timescale 1ns/1ns
module had_tgt_model (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst,
	// sub-window target
	input  wire logic                      tgt_req,
	input  wire logic [had_pkg::OFF_W-1:0] tgt_off,
	output logic                           tgt_ack,
	output logic      [31:0]               tgt_rdata,
	// drawing engine
	output logic                           de_ready,
	output logic                           de_busy,
	// behaviour
	input  wire logic [3:0]                lat,
	input  wire logic                      stall
);
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;
	logic [7:0] cyc_r;
	logic [7:0] cyc_nxt;
	always_comb begin
		cnt_nxt = tgt_req ? cnt_r + 4'h1 : 4'h0;
		cyc_nxt = cyc_r + 8'h01;
		tgt_ack = tgt_req && cnt_r == lat;
		// data only with ack, changing noise otherwise
		tgt_rdata = tgt_ack ? {tgt_off[15:0], 16'hc3a5} : {4{cyc_r}};
		de_ready = !stall;
		de_busy = stall;
	end
	always_ff @(posedge clk) begin
		cnt_r <= rst ? 4'h0 : cnt_nxt;
		cyc_r <= rst ? 8'h00 : cyc_nxt;
	end
endmodule : had_tgt_model

// ### tb.sv
// self-checking bench for the host aperture decoder
`timescale 1ns/1ns
module tb;
	logic                      clk, rst, h_req, h_we, h_ready, h_ack, h_hit;
	logic [1:0]                h_space;
	logic [31:0]               h_addr, h_wdata, h_rdata, tgt_wdata, tgt_rdata, rd, last_wd;
	logic [3:0]                h_be, tgt_be, last_be, lat, be;
	logic                      tgt_req, tgt_we, tgt_swap, tgt_ack, last_swap, stall, last_we;
	had_pkg::had_dst_t         tgt_dst, last_dst;
	logic [had_pkg::OFF_W-1:0] tgt_off;
	logic                      de_valid, de_ready, de_busy, draw_go;
	logic [had_pkg::TAG_W-1:0] de_tag;
	logic [31:0]               de_data, first_data;
	logic [13:0]               first_tag;
	logic                      sync_irq_en, sync_ack, sync_done, sync_irq;
	int                        mismatches, n_tests, go_n, pops, cyc;
	logic [31:0] base [4] = '{32'h1000_0000, 32'h2000_0000, 32'h2080_0000, 32'h3000_0001};
	logic [31:0] offs [10] = '{32'h0, 32'h1000, 32'h2000, 32'h3000, 32'h4000, 32'h5000,
		32'h5800, 32'h6000, 32'h7000, 32'h8000};
	had_pkg::had_dst_t dsts [10] = '{had_pkg::DST_CTRL, had_pkg::DST_MEMCTL,
		had_pkg::DST_QUEUE, had_pkg::DST_VIDTIM, had_pkg::DST_PAL, had_pkg::DST_VSBUS,
		had_pkg::DST_VSCTL, had_pkg::DST_LEGCTL, had_pkg::DST_RSVD, had_pkg::DST_DRAW};
	had_decode u_had_decode (.clk(clk), .rst(rst), .h_req(h_req), .h_space(h_space),
		.h_we(h_we), .h_addr(h_addr), .h_wdata(h_wdata), .h_be(h_be), .h_ready(h_ready),
		.h_ack(h_ack), .h_hit(h_hit), .h_rdata(h_rdata), .tgt_req(tgt_req),
		.tgt_dst(tgt_dst), .tgt_we(tgt_we), .tgt_off(tgt_off), .tgt_wdata(tgt_wdata),
		.tgt_be(tgt_be), .tgt_swap(tgt_swap), .tgt_ack(tgt_ack), .tgt_rdata(tgt_rdata),
		.de_valid(de_valid), .de_ready(de_ready), .de_tag(de_tag), .de_data(de_data),
		.de_busy(de_busy), .draw_go(draw_go), .sync_irq_en(sync_irq_en),
		.sync_ack(sync_ack), .sync_done(sync_done), .sync_irq(sync_irq));
	had_tgt_model u_had_tgt_model (.clk(clk), .rst(rst), .tgt_req(tgt_req),
		.tgt_off(tgt_off), .tgt_ack(tgt_ack), .tgt_rdata(tgt_rdata), .de_ready(de_ready),
		.de_busy(de_busy), .lat(lat), .stall(stall));
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	// capture target accesses, pops and command starts
	always @(posedge clk) begin
		cyc++;
		if (tgt_req && tgt_ack) begin
			last_dst = tgt_dst;
			last_swap = tgt_swap;
			last_wd = tgt_wdata;
			last_be = tgt_be;
			last_we = tgt_we;
		end
		if (draw_go) go_n++;
		if (de_valid && de_ready) begin
			if (pops == 0) {first_tag, first_data} = {de_tag, de_data};
			pops++;
		end
		if (cyc == 20000) begin
			mismatches++;
			final_report;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic acc(input logic [1:0] sp, input logic we, input logic [31:0] a, d);
		int n;
		@(posedge clk);
		#1 {h_req, h_space, h_we, h_addr, h_wdata, h_be} = {1'b1, sp, we, a, d, be};
		@(posedge clk);
		#1 h_req = 0;
		n = 0;
		while (h_ack !== 1'b1 && n < 40) begin
			@(posedge clk);
			#1 n++;
		end
		chk(n < 40, 1);
		rd = h_rdata;
	endtask : acc
	task automatic cw(input logic [5:0] idx, input logic [31:0] d, input logic [31:0] e);
		acc(had_pkg::SP_CFG, 1, {24'h0, idx, 2'h0}, d);
		acc(had_pkg::SP_CFG, 0, {24'h0, idx, 2'h0}, 0);
		chk(rd, e);
	endtask : cw
	task automatic t_config;
		logic [5:0] ix [4] = '{6'h04, 6'h05, 6'h06, 6'h0c};
		logic [31:0] sz [4] = '{32'h2_0000, 32'h80_0000, 32'h80_0000, 32'h1_0000};
		chk(h_ready, 1);
		chk({h_ack, h_hit, de_valid, sync_done, sync_irq, tgt_req}, 0);
		chk(h_rdata, 0);
		acc(had_pkg::SP_CFG, 0, 0, 0);
		chk(rd, had_pkg::CFG_ID_VAL);
		for (int i = 0; i < 4; i++) begin
			cw(ix[i], 32'hffff_ffff, ~(sz[i] - 1) | (i == 3));
			cw(ix[i], base[i], base[i]);
		end
		cw(6'h01, 3, 3);
		$display("test config done");
	endtask : t_config
	task automatic t_windows;
		logic [31:0] a, v;
		logic sw;
		for (int u = 0; u < 2; u++) begin
			lat = 4'(u * 3);
			for (int i = 0; i < 10; i++) begin
				a = base[0] + u * 32'h1_0000 + offs[i] + 32'h10;
				acc(had_pkg::SP_MEM, 0, a, 0);
				chk(h_hit, 1);
				sw = u == 1 && i != 5 && i != 6;
				v = {a[15:0], 16'hc3a5};
				if (i == 2) chk(rd, 32'd256);
				else if (i == 8) chk(rd, 0);
				else begin
					chk(last_dst, dsts[i]);
					chk(last_swap, sw);
					chk(rd, sw ? {<<8{v}} : v);
				end
			end
		end
		be = 4'h1;
		acc(had_pkg::SP_MEM, 1, base[0] + 32'h1_0004, 32'h0102_0304);
		be = 4'hf;
		chk(last_wd, 32'h0403_0201);
		chk(last_be, 4'h8);
		chk(last_we, 1);
		$display("test windows done");
	endtask : t_windows
	task automatic t_regions;
		logic [31:0] ad [7] = '{base[1] + 32'h7f_fffc, base[2], 32'h3000_fffc, 32'h000a_0000,
			32'h3b0, 32'h4000_0000, 32'h3e0};
		logic [15:0] ds [5] = '{16'h0800, 16'h1000, 16'h2000, 16'h4000, 16'h4000};
		for (int i = 0; i < 7; i++) begin
			acc(i == 4 || i == 6 ? had_pkg::SP_IO : had_pkg::SP_MEM, 0, ad[i], 0);
			chk(h_hit, i < 5);
			if (i < 5) chk(last_dst, ds[i]);
			else chk(rd, 0);
		end
		cw(6'h01, 0, 0);
		acc(had_pkg::SP_MEM, 0, base[1], 0);
		chk(h_hit, 0);
		cw(6'h01, 3, 3);
		$display("test regions done");
	endtask : t_regions
	task automatic t_queue;
		int n;
		stall = 1;
		acc(had_pkg::SP_MEM, 1, base[0] + 32'h1_8040, 32'haabb_ccdd);
		acc(had_pkg::SP_MEM, 1, base[0] + 32'h801c, 0);
		acc(had_pkg::SP_MEM, 1, base[0] + 32'h201c, 0);
		acc(had_pkg::SP_MEM, 0, base[0] + 32'h2000, 0);
		chk(rd, 32'd253);
		chk(go_n, 0);
		acc(had_pkg::SP_MEM, 1, base[0] + 32'h818c, 0);
		stall = 0;
		n = 0;
		while (sync_done !== 1'b1 && n < 20) begin
			@(posedge clk);
			#1 n++;
		end
		chk(sync_done, 1);
		chk(sync_irq, 0);
		chk({first_tag, first_data}, {14'h0010, 32'hddcc_bbaa});
		chk(go_n, 1);
		chk(pops, 4);
		sync_irq_en = 1;
		#1 chk(sync_irq, 1);
		@(posedge clk);
		#1 sync_ack = 1;
		@(posedge clk);
		#1 sync_ack = 0;
		chk(sync_done, 0);
		$display("test queue done");
	endtask : t_queue
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : final_report
	initial begin
		{rst, h_req, h_space, h_we, h_addr, h_wdata, h_be} = {1'b1, 72'h0};
		{lat, stall, sync_irq_en, sync_ack} = 0;
		be = 4'hf;
		{mismatches, n_tests, go_n, pops, cyc} = 0;
		repeat (20) @(posedge clk);
		#1 rst = 0;
		t_config;
		t_windows;
		t_regions;
		t_queue;
		final_report;
	end
endmodule : tb
